// File: verilog/pmw_defines.svh
// constants for the power monitor warning and status block
`ifndef PMW_DEFINES_SVH
`define PMW_DEFINES_SVH

`define PMW_ADDR_W 8
`define PMW_A_CTRL 8'h00
`define PMW_A_STATUS 8'h04
`define PMW_A_VIN_HI 8'h08
`define PMW_A_VIN_LO 8'h0C
`define PMW_A_LOAD_SIDE_VOLTAGE_PIN_HI 8'h10
`define PMW_A_LOAD_SIDE_VOLTAGE_PIN_LO 8'h14
`define PMW_A_CUR_HI 8'h18
`define PMW_A_CUR2 8'h1C
`define PMW_A_RD_VIN 8'h20
`define PMW_A_RD_LOAD_SIDE_VOLTAGE_PIN 8'h24
`define PMW_A_RD_CUR 8'h28
`define PMW_A_PK_VIN 8'h2C
`define PMW_A_PK_LOAD_SIDE_VOLTAGE_PIN 8'h30
`define PMW_A_PK_CUR 8'h34
`define PMW_A_LSB 8'h38

// ctrl register bits
`define PMW_C_CLEAR 0
`define PMW_C_OUT_ON 1
`define PMW_C_CUR2_UNDER 2
`define PMW_C_RANGE20 3

// status bits
`define PMW_S_COMM 0
`define PMW_S_REGT 1
`define PMW_S_CUR_HI 2
`define PMW_S_CUR2 3
`define PMW_S_VIN_LO 4
`define PMW_S_VIN_HI 5
`define PMW_S_LOAD_SIDE_VOLTAGE_PIN_LO 6
`define PMW_S_LOAD_SIDE_VOLTAGE_PIN_HI 7
`define PMW_S_F_LOW 8
`define PMW_S_F_HIGH 9
`define PMW_S_F_TIMER 10
`define PMW_NSTAT 11

`define PMW_CODE_MIN 12'h000
`define PMW_CODE_MAX 12'hFFF
`define PMW_CUR_ZERO 12'h800
// step sizes in nanovolts
`define PMW_LSB_CUR_NV 16'h3070
`define PMW_LSB_6V_NV 32'h0016B480
`define PMW_LSB_20V_NV 32'h004F77C0

`endif

// File: verilog/pmw_pkg.sv
// types for the power monitor warning and status block
package pmw_pkg;
    typedef struct packed {
        logic vin_valid;
        logic load_side_voltage_pin_valid;
        logic cur_valid;
        logic [11:0] vin_code;
        logic [11:0] load_side_voltage_pin_code;
        logic [11:0] cur_code;
    } pmw_sample_t;

    typedef struct packed {
        logic low_trip;
        logic high_trip;
        logic timer_expired;
        logic regulating;
        logic comm_error;
    } pmw_event_t;
endpackage

// File: verilog/pmw_monitor.sv
// warning comparison, readback and status latching for a hot-swap monitor
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/100ps
`include "pmw_defines.svh"
module pmw_monitor
    import pmw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pmw_sample_t sample,
    input wire logic [4:0] event_pins,
    output logic output_enable,
    output logic [10:0] status_out
);
    // =========================================================
    // pin synchronisers (three stages, second and third agree)
    // =========================================================
    logic [4:0] ev_s1_reg, ev_s2_reg, ev_s3_reg, ev_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_s1_reg <= 5'h00;
            ev_s2_reg <= 5'h00;
            ev_s3_reg <= 5'h00;
        end else begin
            ev_s1_reg <= event_pins;
            ev_s2_reg <= ev_s1_reg;
            ev_s3_reg <= ev_s2_reg;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_reg <= 5'h00;
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (ev_s2_reg[i] == ev_s3_reg[i]) begin
                    ev_reg[i] <= ev_s3_reg[i];
                end
            end
        end
    end
    pmw_event_t ev;
    assign ev = pmw_event_t'(ev_reg);

    // =========================================================
    // register file
    // =========================================================
    logic [11:0] vin_hi_reg, vin_lo_reg, load_side_voltage_pin_hi_reg, load_side_voltage_pin_lo_reg;
    logic [11:0] cur_hi_reg, cur2_reg;
    logic [11:0] rd_vin_reg, rd_load_side_voltage_pin_reg, rd_cur_reg;
    logic [11:0] pk_vin_reg, pk_load_side_voltage_pin_reg, pk_cur_reg;
    logic cur2_under_reg, range20_reg, out_on_reg;
    logic [10:0] status_reg;
    logic wr_en, rd_en, clear_pulse, out_off_pulse;
    logic unmapped;

    // upper address bits would alias onto the map, so refused writes are dropped
    assign wr_en = psel && penable && pwrite && !unmapped;
    assign rd_en = psel && penable && !pwrite;
    assign clear_pulse = wr_en && pstrb[0] && paddr[7:0] == `PMW_A_CTRL
        && pwdata[`PMW_C_CLEAR];
    assign out_off_pulse = wr_en && pstrb[0] && paddr[7:0] == `PMW_A_CTRL
        && !pwdata[`PMW_C_OUT_ON] && out_on_reg;

    function automatic logic [11:0] wr12(input logic [11:0] old);
        wr12 = {pstrb[1] ? pwdata[11:8] : old[11:8], pstrb[0] ? pwdata[7:0] : old[7:0]};
    endfunction

    // direct format: four-byte word, raw codes zero-extended
    function automatic logic [31:0] dword(input logic [11:0] c);
        dword = {16'h0000, 4'h0, c};
    endfunction

    // thresholds reset so that no warning can fire
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vin_hi_reg <= `PMW_CODE_MAX;
            vin_lo_reg <= `PMW_CODE_MIN;
            load_side_voltage_pin_hi_reg <= `PMW_CODE_MAX;
            load_side_voltage_pin_lo_reg <= `PMW_CODE_MIN;
            cur_hi_reg <= `PMW_CODE_MAX;
            cur2_reg <= `PMW_CODE_MAX;
        end else if (wr_en) begin
            unique case (paddr[7:0])
                `PMW_A_VIN_HI: vin_hi_reg <= wr12(vin_hi_reg);
                `PMW_A_VIN_LO: vin_lo_reg <= wr12(vin_lo_reg);
                `PMW_A_LOAD_SIDE_VOLTAGE_PIN_HI: load_side_voltage_pin_hi_reg <= wr12(load_side_voltage_pin_hi_reg);
                `PMW_A_LOAD_SIDE_VOLTAGE_PIN_LO: load_side_voltage_pin_lo_reg <= wr12(load_side_voltage_pin_lo_reg);
                `PMW_A_CUR_HI: cur_hi_reg <= wr12(cur_hi_reg);
                `PMW_A_CUR2: cur2_reg <= wr12(cur2_reg);
                default: ;
            endcase
        end
    end

    // control: polarity of second threshold, range, output on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur2_under_reg <= 1'b0;
            range20_reg <= 1'b0;
            out_on_reg <= 1'b1;
        end else if (wr_en && pstrb[0] && paddr[7:0] == `PMW_A_CTRL) begin
            cur2_under_reg <= pwdata[`PMW_C_CUR2_UNDER];
            range20_reg <= pwdata[`PMW_C_RANGE20];
            out_on_reg <= pwdata[`PMW_C_OUT_ON];
        end
    end

    // =========================================================
    // readback and peak hold, raw codes
    // =========================================================
    function automatic logic pk_clr(input logic [7:0] a);
        pk_clr = wr_en && paddr[7:0] == a && pwdata[15:0] == 16'h0000;
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_vin_reg <= 12'h000;
            rd_load_side_voltage_pin_reg <= 12'h000;
            rd_cur_reg <= 12'h000;
        end else begin
            if (sample.vin_valid) rd_vin_reg <= sample.vin_code;
            if (sample.load_side_voltage_pin_valid) rd_load_side_voltage_pin_reg <= sample.load_side_voltage_pin_code;
            if (sample.cur_valid) rd_cur_reg <= sample.cur_code;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pk_vin_reg <= 12'h000;
            pk_load_side_voltage_pin_reg <= 12'h000;
            pk_cur_reg <= 12'h000;
        end else begin
            if (pk_clr(`PMW_A_PK_VIN)) pk_vin_reg <= 12'h000;
            else if (sample.vin_valid && sample.vin_code > pk_vin_reg)
                pk_vin_reg <= sample.vin_code;
            if (pk_clr(`PMW_A_PK_LOAD_SIDE_VOLTAGE_PIN)) pk_load_side_voltage_pin_reg <= 12'h000;
            else if (sample.load_side_voltage_pin_valid && sample.load_side_voltage_pin_code > pk_load_side_voltage_pin_reg)
                pk_load_side_voltage_pin_reg <= sample.load_side_voltage_pin_code;
            if (pk_clr(`PMW_A_PK_CUR)) pk_cur_reg <= 12'h000;
            else if (sample.cur_valid && sample.cur_code > pk_cur_reg)
                pk_cur_reg <= sample.cur_code;
        end
    end

    // =========================================================
    // condition detection
    // =========================================================
    logic [10:0] cond;
    always_comb begin
        cond = 11'h000;
        cond[`PMW_S_COMM] = ev.comm_error;
        cond[`PMW_S_REGT] = ev.regulating;
        // strict compares, only on a finished sample of that channel
        cond[`PMW_S_CUR_HI] = sample.cur_valid && sample.cur_code > cur_hi_reg;
        cond[`PMW_S_CUR2] = sample.cur_valid && (cur2_under_reg ?
            sample.cur_code < cur2_reg : sample.cur_code > cur2_reg);
        cond[`PMW_S_VIN_LO] = sample.vin_valid && sample.vin_code < vin_lo_reg;
        cond[`PMW_S_VIN_HI] = sample.vin_valid && sample.vin_code > vin_hi_reg;
        cond[`PMW_S_LOAD_SIDE_VOLTAGE_PIN_LO] = sample.load_side_voltage_pin_valid && sample.load_side_voltage_pin_code < load_side_voltage_pin_lo_reg;
        cond[`PMW_S_LOAD_SIDE_VOLTAGE_PIN_HI] = sample.load_side_voltage_pin_valid && sample.load_side_voltage_pin_code > load_side_voltage_pin_hi_reg;
        // faults always watched, no mask exists
        cond[`PMW_S_F_LOW] = ev.low_trip;
        cond[`PMW_S_F_HIGH] = ev.high_trip;
        cond[`PMW_S_F_TIMER] = ev.timer_expired;
    end

    // =========================================================
    // sticky status; set wins over clear
    // =========================================================
    logic [10:0] status_next;
    always_comb begin
        status_next = status_reg;
        if (clear_pulse || out_off_pulse) status_next = 11'h000;
        status_next = status_next | cond;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= 11'h000;
        end else begin
            status_reg <= status_next;
        end
    end

    // warnings never reach the output switch any fault turns it off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_enable <= 1'b0;
        end else begin
            output_enable <= out_on_reg && !(|cond[10:8]);
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) status_out <= 11'h000;
        else status_out <= status_next;
    end

    // =========================================================
    // apb read path, no wait state, data registered in the setup cycle
    // =========================================================
    logic [31:0] rdata;
    always_comb begin
        unique case (paddr[7:0])
            `PMW_A_CTRL: rdata = {28'h0000000, range20_reg, cur2_under_reg, out_on_reg, 1'b0};
            `PMW_A_STATUS: rdata = {21'h000000, status_reg};
            `PMW_A_VIN_HI: rdata = dword(vin_hi_reg);
            `PMW_A_VIN_LO: rdata = dword(vin_lo_reg);
            `PMW_A_LOAD_SIDE_VOLTAGE_PIN_HI: rdata = dword(load_side_voltage_pin_hi_reg);
            `PMW_A_LOAD_SIDE_VOLTAGE_PIN_LO: rdata = dword(load_side_voltage_pin_lo_reg);
            `PMW_A_CUR_HI: rdata = dword(cur_hi_reg);
            `PMW_A_CUR2: rdata = dword(cur2_reg);
            `PMW_A_RD_VIN: rdata = dword(rd_vin_reg);
            `PMW_A_RD_LOAD_SIDE_VOLTAGE_PIN: rdata = dword(rd_load_side_voltage_pin_reg);
            `PMW_A_RD_CUR: rdata = dword(rd_cur_reg);
            `PMW_A_PK_VIN: rdata = dword(pk_vin_reg);
            `PMW_A_PK_LOAD_SIDE_VOLTAGE_PIN: rdata = dword(pk_load_side_voltage_pin_reg);
            `PMW_A_PK_CUR: rdata = dword(pk_cur_reg);
            // voltage step in nanovolts for the chosen range
            `PMW_A_LSB: rdata = range20_reg ? `PMW_LSB_20V_NV : `PMW_LSB_6V_NV;
            default: rdata = 32'h00000000;
        endcase
    end
    assign unmapped = paddr[31:8] != 24'h000000 || paddr[7:0] > `PMW_A_LSB
        || paddr[1:0] != 2'b00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                pready <= 1'b1;
                pslverr <= unmapped;
                prdata <= (pwrite || unmapped) ? 32'h00000000 : rdata;
            end
        end
    end
endmodule

// File: sim/pmw_props_properties.sv
// concurrent checks on the ports of the warning and status block
`timescale 1ns/100ps
module pmw_props
    import pmw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire pmw_sample_t sample,
    input wire logic [4:0] event_pins,
    input wire logic output_enable,
    input wire logic [10:0] status_out
);
    wire ctrl_wr = psel && penable && pwrite && paddr[7:0] == 8'h00;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========
    // latching and faults
    latch_hold_a: assert property (!ctrl_wr |=>
        (status_out & $past(status_out)) == $past(status_out)) else $error("status bit dropped");
    // a host write may re-enable briefly, so it restarts the window
    fault_off_a: assert property ((event_pins[4:2] != 3'b000 && !ctrl_wr) [*8]
        |-> !output_enable) else $error("output on during fault");
    low_stat_a: assert property (event_pins[4] [*8] |-> status_out[8])
        else $error("low trip not in status");
    timer_stat_a: assert property (event_pins[2] [*8] |-> status_out[10])
        else $error("timer fault not in status");
    comm_stat_a: assert property (event_pins[0] [*8] |-> status_out[0])
        else $error("comm error not in status");
    regt_stat_a: assert property (event_pins[1] [*8] |-> status_out[1])
        else $error("regulation not in status");
    warn_only_a: assert property ($fell(output_enable) |-> $past(ctrl_wr) ||
        $past(ctrl_wr, 2) || status_out[10:8] != 3'b000) else $error("output off without fault");
    warn_cause_a: assert property ((status_out[7:2] & ~$past(status_out[7:2])) != 6'h00
        |-> $past(sample.vin_valid || sample.load_side_voltage_pin_valid || sample.cur_valid))
        else $error("warning without sample");
    cover property (ctrl_wr ##1 status_out != 11'h000);
    cover property (pready && pslverr);
    cover property ($fell(output_enable));
endmodule

// File: sim/pmw_front.sv
// far-side source of converter samples and analog event pins
`timescale 1ns/100ps
module pmw_front
    import pmw_pkg::*;
(
    input wire logic pclk,
    output pmw_sample_t sample,
    output logic [4:0] event_pins
);
    initial begin
        sample = '0;
        event_pins = 5'h00;
    end
    // idle codes inverted so a stale code never looks like a fresh one
    task automatic send(input logic [1:0] ch, input logic [11:0] code);
        @(posedge pclk);
        sample <= {ch == 2'd0, ch == 2'd1, ch == 2'd2, code, code, code};
        @(posedge pclk);
        sample <= {3'b000, ~code, ~code, ~code};
    endtask
    task automatic pins(input logic [4:0] v);
        event_pins <= v;
    endtask
endmodule

// File: sim/testbench.sv
// self-checking bench for the warning and status block
`timescale 1ns/100ps
module testbench;
    import pmw_pkg::*;
    typedef struct {logic [7:0] a; logic [11:0] thr; logic [1:0] ch; logic [11:0] code;
        int idx; logic exp;} pmw_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, output_enable, er;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [10:0] status_out;
    logic [4:0] event_pins;
    pmw_sample_t sample;
    int num_errors = 0;
    int checked = 0;
    logic [11:0] dflt[6] = '{12'hFFF, 12'h000, 12'hFFF, 12'h000, 12'hFFF, 12'hFFF};
    pmw_row_t rows[10] = '{
        '{8'h08, 12'h800, 2'd0, 12'h800, 5, 1'b0}, '{8'h08, 12'h800, 2'd0, 12'h801, 5, 1'b1},
        '{8'h0C, 12'h400, 2'd0, 12'h400, 4, 1'b0}, '{8'h0C, 12'h400, 2'd0, 12'h3FF, 4, 1'b1},
        '{8'h10, 12'hA00, 2'd1, 12'hA01, 7, 1'b1}, '{8'h14, 12'h001, 2'd1, 12'h000, 6, 1'b1},
        '{8'h18, 12'h800, 2'd2, 12'h800, 2, 1'b0}, '{8'h18, 12'h800, 2'd2, 12'h801, 2, 1'b1},
        '{8'h1C, 12'h800, 2'd2, 12'h7FF, 3, 1'b0}, '{8'h1C, 12'h800, 2'd2, 12'hFFF, 3, 1'b1}};
    pmw_monitor dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample(sample), .event_pins(event_pins),
        .output_enable(output_enable), .status_out(status_out));
    pmw_front front (.pclk(pclk), .sample(sample), .event_pins(event_pins));
    // ==========
    // bus and checking tasks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task stop_test;
        if (num_errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        stop_test;
    end
    // ==========
    // main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            apb(1'b0, 8'h08 + 8'(k * 4), 32'h0, rd, er);
            chk("threshold", rd, {20'h0, dflt[k]});
        end
        front.send(2'd0, 12'hFFF);
        front.send(2'd2, 12'h000);
        apb(1'b0, 8'h04, 32'h0, rd, er);
        chk("quiet", rd, 32'h0);
        apb(1'b0, 8'h2C, 32'h0, rd, er);
        chk("peak", rd, 32'hFFF);
        apb(1'b1, 8'h2C, 32'h0, rd, er);
        apb(1'b0, 8'h2C, 32'h0, rd, er);
        chk("peak clear", rd, 32'h0);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, {20'h0, rows[i].thr}, rd, er);
            front.send(rows[i].ch, rows[i].code);
            apb(1'b0, 8'h04, 32'h0, rd, er);
            chk("status", rd, {31'h0, rows[i].exp} << rows[i].idx);
            chk("status out", {21'h0, status_out}, {31'h0, rows[i].exp} << rows[i].idx);
            apb(1'b0, 8'h20 + 8'(rows[i].ch) * 8'h04, 32'h0, rd, er);
            chk("readback", rd, {20'h0, rows[i].code});
            apb(1'b1, rows[i].a, rows[i].a[2] && rows[i].a != 8'h1C ? 32'h0 : 32'hFFF, rd, er);
            apb(1'b1, 8'h00, 32'h3, rd, er);
        end
        apb(1'b1, 8'h00, 32'h6, rd, er);
        apb(1'b1, 8'h1C, 32'h800, rd, er);
        front.send(2'd2, 12'h7FF);
        apb(1'b0, 8'h04, 32'h0, rd, er);
        chk("under", rd, 32'h8);
        apb(1'b1, 8'h1C, 32'hFFF, rd, er);
        apb(1'b1, 8'h00, 32'h3, rd, er);
        apb(1'b0, 8'h38, 32'h0, rd, er);
        chk("step 6v", rd, 32'd1488000);
        apb(1'b1, 8'h00, 32'hA, rd, er);
        apb(1'b0, 8'h38, 32'h0, rd, er);
        chk("step 20v", rd, 32'd5208000);
        apb(1'b1, 8'h00, 32'h2, rd, er);
        for (int p = 4; p >= 0; p--) begin
            front.pins(5'(1 << p));
            repeat (10) @(posedge pclk);
            chk("enable", {31'h0, output_enable}, 32'(p < 2));
            apb(1'b1, 8'h00, 32'h3, rd, er);
            apb(1'b0, 8'h04, 32'h0, rd, er);
            chk("held", rd, p < 2 ? 32'h1 << p : 32'h1 << (12 - p));
            front.pins(5'h00);
            repeat (10) @(posedge pclk);
            apb(1'b1, 8'h00, 32'h0, rd, er);
            apb(1'b1, 8'h00, 32'h2, rd, er);
            apb(1'b0, 8'h04, 32'h0, rd, er);
            chk("cleared", rd, 32'h0);
            chk("on", {31'h0, output_enable}, 32'h1);
        end
        apb(1'b0, 8'h3C, 32'h0, rd, er);
        chk("unmapped", {31'h0, er}, 32'h1);
        apb(1'b0, 8'h05, 32'h0, rd, er);
        chk("misaligned", {31'h0, er}, 32'h1);
        stop_test;
    end
endmodule
bind pmw_monitor pmw_props props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample(sample),
    .event_pins(event_pins), .output_enable(output_enable), .status_out(status_out));
